// ### core/pmrs_top.sv
// Power-mode and reset sequencer with APB register slave
`timescale 1ns/100ps
module pmrs_top
  import pmrs_pkg::*;
#(
  parameter int NMOD        = 8,
  parameter int POR_CNT     = POR_CYCLES,
  parameter int PLL_CNT     = PLL_CYCLES,
  parameter int XTAL_CNT    = XTAL_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              chip_power_enable_pin,
  input  wire logic              supply_ok,
  input  wire logic              host_wake,
  input  wire logic              boot_strap_bit2,
  input  wire logic              boot_strap_bit1,
  input  wire logic              boot_strap_bit0,
  input  wire logic [NMOD-1:0]   mod_sleep_req,
  output logic                   core_power_q,
  output logic                   sleep_clk_en_q,
  output logic                   xtal_en_q,
  output logic                   digital_phase_loop_en_q,
  output logic                   radio_en_q,
  output logic                   clk_full_speed_q,
  output logic                   code_load_state_q,
  output logic                   boot_usb_sel_q,
  output logic [NMOD-1:0]        mod_clk_en_q,
  output logic [NMOD-1:0]        mod_power_q,
  output logic [NMOD-1:0]        mod_rst_n_q
);

  // ****************************************
  // Resets
  // ****************************************
  // Enable pin low acts without a clock; bus side keeps answering
  logic sys_rst_n;
  assign sys_rst_n = presetn & chip_power_enable_pin;

  pmrs_state_t       state_q;
  pmrs_state_t       state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [31:0]       sleep_tmr_q;
  logic              lockout_q;
  logic [2:0]        strap_q;
  logic              strap_done_q;
  pmrs_ctrl_t        ctrl_q;
  logic [NMOD-1:0]   clken_q;
  logic [31:0]       slptm_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic              wr_en;
  logic              hit;
  logic              cnt_zero;
  logic              timer_hit;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: ready follows the first access cycle
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign hit   = (paddr == CTRL_OFS) | (paddr == CLKEN_OFS) |
                 (paddr == SLPTM_OFS) | (paddr == STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      prdata_q  <= 32'h00000000;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          CTRL_OFS:   prdata_q[CTRL_FULL_BIT] <= ctrl_q.full_speed;
          CLKEN_OFS:  prdata_q[NMOD-1:0] <= clken_q;
          SLPTM_OFS:  prdata_q <= slptm_q;
          STATUS_OFS: begin
            prdata_q[$bits(pmrs_state_t)-1:0] <= state_q;
            prdata_q[STAT_BOOT_BIT]           <= boot_usb_sel_q;
            prdata_q[STAT_LOCK_BIT]           <= lockout_q;
          end
          default:    prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Command bits are one-cycle pulses; full speed is a level
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ctrl_q  <= '0;
      clken_q <= CLKEN_RST[NMOD-1:0];
      slptm_q <= SLPTM_RST;
    end else begin
      ctrl_q.start_cmd  <= 1'b0;
      ctrl_q.active_cmd <= 1'b0;
      ctrl_q.sleep_cmd  <= 1'b0;
      if (wr_en && paddr == CTRL_OFS) begin
        ctrl_q.start_cmd  <= pwdata[CTRL_START_BIT];
        ctrl_q.active_cmd <= pwdata[CTRL_ACTIVE_BIT];
        ctrl_q.sleep_cmd  <= pwdata[CTRL_SLEEP_BIT];
        ctrl_q.full_speed <= pwdata[CTRL_FULL_BIT];
      end
      if (wr_en && paddr == CLKEN_OFS) begin
        clken_q <= pwdata[NMOD-1:0];
      end
      if (wr_en && paddr == SLPTM_OFS) begin
        slptm_q <= pwdata;
      end
    end
  end

  // ****************************************
  // Boot straps
  // ****************************************
  // Caught by a clocked process after release, never by the reset
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      strap_q        <= STRAP_FLASH;
      strap_done_q   <= 1'b0;
      boot_usb_sel_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q        <= {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0};
      strap_done_q   <= 1'b1;
      boot_usb_sel_q <= ({boot_strap_bit2, boot_strap_bit1, boot_strap_bit0} == STRAP_USB);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign cnt_zero  = (cnt_q == '0);
  assign timer_hit = (slptm_q != 32'h00000000) && (sleep_tmr_q == 32'h00000000);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF:   if (supply_ok && !lockout_q) state_d = ST_POR;
      ST_POR:   if (cnt_zero) state_d = ST_WAIT;
      ST_WAIT:  if (ctrl_q.start_cmd) state_d = ST_PLL;
      ST_PLL:   if (cnt_zero) state_d = ST_LOAD;
      ST_LOAD:  if (ctrl_q.active_cmd) state_d = ST_ACT;
      ST_ACT:   if (ctrl_q.sleep_cmd) state_d = ST_SLEEP;
      ST_SLEEP: if (host_wake || timer_hit) state_d = ST_WARM;
      ST_WARM:  if (cnt_zero && xtal_en_q && digital_phase_loop_en_q) state_d = ST_ACT;
      default:  state_d = ST_OFF;
    endcase
    if (state_q != ST_OFF && !supply_ok) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_q   <= ST_OFF;
      lockout_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_OFF && !supply_ok) begin
        lockout_q <= 1'b1;
      end
    end
  end

  // Settle counter; warm-up runs the crystal wait then the loop wait
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      cnt_q <= CNT_W'(POR_CNT - 1);
    end else if (state_d != state_q) begin
      case (state_d)
        ST_POR:  cnt_q <= CNT_W'(POR_CNT - 1);
        ST_PLL:  cnt_q <= CNT_W'(PLL_CNT - 1);
        ST_WARM: cnt_q <= CNT_W'(XTAL_CNT - 1);
        default: cnt_q <= '0;
      endcase
    end else if (state_q == ST_WARM && cnt_zero && !digital_phase_loop_en_q) begin
      cnt_q <= CNT_W'(PLL_CNT - 1);
    end else if (!cnt_zero) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Sleep timer loads on entry and counts down while asleep
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sleep_tmr_q <= SLPTM_RST;
    end else if (state_q != ST_SLEEP) begin
      sleep_tmr_q <= slptm_q;
    end else if (sleep_tmr_q != 32'h00000000) begin
      sleep_tmr_q <= sleep_tmr_q - 1'b1;
    end
  end

  // ****************************************
  // Power, clock and reset outputs
  // ****************************************
  // Crystal rises in the POR window so the clock settles in time
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      core_power_q            <= 1'b0;
      sleep_clk_en_q          <= 1'b0;
      xtal_en_q               <= 1'b0;
      digital_phase_loop_en_q <= 1'b0;
      radio_en_q              <= 1'b0;
      clk_full_speed_q        <= 1'b0;
      code_load_state_q       <= 1'b0;
    end else begin
      core_power_q      <= (state_d != ST_OFF);
      sleep_clk_en_q    <= (state_d != ST_OFF);
      xtal_en_q         <= (state_d != ST_OFF) && (state_d != ST_SLEEP);
      digital_phase_loop_en_q <= xtal_en_q && (state_d == ST_PLL || state_d == ST_LOAD ||
                                 state_d == ST_ACT || (state_d == ST_WARM && state_q == ST_WARM &&
                                 (cnt_zero || digital_phase_loop_en_q)));
      radio_en_q        <= (state_d == ST_ACT);
      // Crystal clock until code load or active and host asks for speed
      clk_full_speed_q  <= ctrl_q.full_speed && (state_d == ST_LOAD || state_d == ST_ACT);
      code_load_state_q <= (state_d == ST_LOAD);
    end
  end

  // Per-module gating: register enable and module sleep request
  always_ff @(posedge pclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mod_clk_en_q <= '0;
      mod_power_q  <= '0;
      mod_rst_n_q  <= '0;
    end else begin
      mod_clk_en_q <= (state_d == ST_ACT || state_d == ST_LOAD) ?
                      (clken_q & ~mod_sleep_req) : '0;
      mod_power_q  <= (state_d == ST_OFF || state_d == ST_POR || state_d == ST_WAIT) ? '0 :
                      (state_d == ST_SLEEP) ? ~mod_sleep_req : {NMOD{1'b1}};
      // Held through sleep so state is kept; released once clocks stable
      mod_rst_n_q  <= (state_d == ST_LOAD || state_d == ST_ACT || state_d == ST_SLEEP ||
                       state_d == ST_WARM) ? {NMOD{1'b1}} : '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence wake_ev;
    state_q == ST_SLEEP && (host_wake || timer_hit) && supply_ok;
  endsequence

  sequence pll_done;
    state_q == ST_PLL && cnt_zero && supply_ok;
  endsequence

  pwr_down_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_power_enable_pin |-> state_q == ST_OFF && !core_power_q && !sleep_clk_en_q)
    else $error("powered-down state not held while enable low");

  por_count_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    $rose(state_q == ST_POR) |-> cnt_q == CNT_W'(POR_CNT - 1))
    else $error("power-on settle count wrong");

  xtal_first_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    digital_phase_loop_en_q |-> xtal_en_q && $past(xtal_en_q))
    else $error("loop enabled without running crystal");

  sleep_quiet_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_SLEEP && $past(state_q) == ST_SLEEP |->
      !radio_en_q && !digital_phase_loop_en_q && !xtal_en_q && mod_rst_n_q == {NMOD{1'b1}})
    else $error("circuits left on or state lost in sleep");

  wake_go_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    wake_ev |=> state_q == ST_WARM ##1 xtal_en_q)
    else $error("no clock restart after wake");

  reset_release_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    pll_done |=> mod_rst_n_q == {NMOD{1'b1}} && code_load_state_q && digital_phase_loop_en_q)
    else $error("resets not released after clocks stable");

  clk_gate_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_ACT && $past(state_q) == ST_ACT |->
      mod_clk_en_q == ($past(clken_q) & ~$past(mod_sleep_req)))
    else $error("module clock enables disagree with control");

  strap_boot_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    strap_done_q |-> boot_usb_sel_q == (strap_q == STRAP_USB))
    else $error("boot interface disagrees with straps");

  lockout_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q != ST_OFF && !supply_ok |=> state_q == ST_OFF && lockout_q ##1 state_q == ST_OFF)
    else $error("low supply did not force lockout");

  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("bus answer timing wrong");

  sequence warm_done;
    state_q == ST_WARM ##1 state_q == ST_ACT;
  endsequence

  off_quiet_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_OFF |-> !core_power_q && !sleep_clk_en_q && mod_power_q == '0)
    else $error("power or sleep clock on while powered down");

  por_done_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_POR && cnt_zero && supply_ok |=> state_q == ST_WAIT && core_power_q && xtal_en_q)
    else $error("power-on settle did not end in waiting state");

  load_entry_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_LOAD |-> code_load_state_q && digital_phase_loop_en_q)
    else $error("code-load state without loop running");

  sleep_keep_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_SLEEP |-> !xtal_en_q && mod_rst_n_q == {NMOD{1'b1}} && $stable(boot_usb_sel_q))
    else $error("crystal on or state disturbed in sleep");

  warm_start_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_WARM && $past(state_q) == ST_SLEEP |->
      xtal_en_q && !digital_phase_loop_en_q && !radio_en_q)
    else $error("clock restart did not begin with crystal alone");

  warm_exit_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    warm_done |-> $past(digital_phase_loop_en_q) && radio_en_q)
    else $error("active reached before loop was running");

  crystal_clock_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q inside {ST_POR, ST_WAIT, ST_PLL} |-> !clk_full_speed_q)
    else $error("full speed clock before code load");

  hold_reset_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_WAIT |-> mod_rst_n_q == '0 && mod_power_q == '0 && mod_clk_en_q == '0)
    else $error("modules released before host start");

  strap_sample_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    $rose(strap_done_q) |-> strap_q == $past({boot_strap_bit2, boot_strap_bit1, boot_strap_bit0}))
    else $error("straps not taken at boot");

  module_gate_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_SLEEP && $past(state_q) == ST_SLEEP |-> mod_power_q == ~$past(mod_sleep_req))
    else $error("module power ignores sleep requests");

  supply_block_a: assert property (@(posedge pclk) disable iff (!sys_rst_n)
    state_q == ST_OFF && (!supply_ok || lockout_q) |=> state_q == ST_OFF && !core_power_q)
    else $error("started despite low supply or lockout");

endmodule

// ### core/pmrs_pkg.sv
// Constants, types and state codes of the power-mode and reset sequencer
package pmrs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 20;
  localparam int POR_TIME_NS      = 1300000;
  localparam int PLL_SETTLE_NS    = 100000;
  localparam int POR_CYCLES       = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int PLL_CYCLES       = PLL_SETTLE_NS / CLK_PERIOD_NS;
  localparam int XTAL_CYCLES      = 32;
  localparam int CNT_W            = 17;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] CLKEN_OFS  = 12'h004;
  localparam logic [11:0] SLPTM_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_SLEEP_BIT  = 2;
  localparam int CTRL_FULL_BIT   = 3;
  localparam int STAT_BOOT_BIT   = 8;
  localparam int STAT_LOCK_BIT   = 9;
  localparam logic [31:0] CLKEN_RST = 32'hffffffff;
  localparam logic [31:0] SLPTM_RST = 32'h00000000;

  // ****************************************
  // Straps and states
  // ****************************************
  localparam logic [2:0] STRAP_FLASH = 3'h0;
  localparam logic [2:0] STRAP_USB   = 3'h6;

  typedef enum logic [7:0] {
    ST_OFF   = 8'h01,
    ST_POR   = 8'h02,
    ST_WAIT  = 8'h04,
    ST_PLL   = 8'h08,
    ST_LOAD  = 8'h10,
    ST_ACT   = 8'h20,
    ST_SLEEP = 8'h40,
    ST_WARM  = 8'h80
  } pmrs_state_t;

  typedef struct packed {
    logic full_speed;
    logic sleep_cmd;
    logic active_cmd;
    logic start_cmd;
  } pmrs_ctrl_t;

endpackage

// ### tb/pmrs_host_model.sv
// Host controller model: drives the power enable pin and the wake line
`timescale 1ns/100ps
module pmrs_host_model (
  input  wire logic pclk,
  input  wire logic power_req,
  input  wire logic wake_req,
  output logic      chip_power_enable_pin,
  output logic      host_wake
);
  // ****************************************
  // Pin drivers
  // ****************************************
  // Both pins are plain push-pull levels, changed only just after an edge
  initial chip_power_enable_pin = 1'b0;
  initial host_wake = 1'b0;
  always @(posedge pclk) begin
    chip_power_enable_pin <= power_req;
    host_wake             <= wake_req;
  end
endmodule

// ### tb/testbench.sv
// Self-checking testbench of the power-mode and reset sequencer
`timescale 1ns/100ps
module testbench
  import pmrs_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        power_req, wake_req, pin_en, wake, supply_ok, b2, b1, b0, err;
  logic [7:0]  req, clk_en, pwr, rst_n;
  logic        core_pwr, slp_clk, xtal, loop_en, radio, full, load, usb;
  int          fail_count, tests_run, cyc, n;

  pmrs_top #(.NMOD(8), .POR_CNT(20), .PLL_CNT(10), .XTAL_CNT(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_power_enable_pin(pin_en), .supply_ok(supply_ok), .host_wake(wake),
    .boot_strap_bit2(b2), .boot_strap_bit1(b1), .boot_strap_bit0(b0), .mod_sleep_req(req),
    .core_power_q(core_pwr), .sleep_clk_en_q(slp_clk), .xtal_en_q(xtal),
    .digital_phase_loop_en_q(loop_en), .radio_en_q(radio), .clk_full_speed_q(full),
    .code_load_state_q(load), .boot_usb_sel_q(usb), .mod_clk_en_q(clk_en),
    .mod_power_q(pwr), .mod_rst_n_q(rst_n));

  pmrs_host_model i_host (.pclk(pclk), .power_req(power_req), .wake_req(wake_req),
    .chip_power_enable_pin(pin_en), .host_wake(wake));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits as long as the slave asks; only the global timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_st(input logic [7:0] st);
    int k;
    k = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0);
      k++;
    end while (rd[7:0] !== st && k < 100);
    chk("state", {24'h0, rd[7:0]}, {24'h0, st});
  endtask

  task automatic endt(input string name);
    $display("test %s done, %0d checks so far", name, tests_run);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Power pulse that restarts the whole sequencer from off
  task automatic power_cycle(input logic [2:0] strap);
    @(posedge pclk);
    power_req    <= 1'b0;
    {b2, b1, b0} <= strap;
    repeat (3) @(posedge pclk);
    power_req <= 1'b1;
  endtask

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    power_req = 1'b0;
    wake_req = 1'b0;
    supply_ok = 1'b1;
    req = 8'h00;
    {b2, b1, b0} = 3'h6;
    fail_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(ST_OFF);
    chk("off power", {core_pwr, slp_clk, rst_n, pwr}, 18'h0);
    endt("off");
    // Bound of 1.3 ms is 65000 cycles; the shortened count is 20
    power_req <= 1'b1;
    wait_st(ST_WAIT);
    chk("boot status", rd, 32'h104);
    chk("usb select", {31'h0, usb}, 32'h1);
    chk("por clocks", {core_pwr, xtal, loop_en, full}, 4'hc);
    chk("clken reset", {24'h0, clk_en}, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
    for (n = 0; n < 20 && loop_en !== 1'b1; n++) @(posedge pclk);
    chk("loop after start", {xtal, loop_en}, 2'h3);
    wait_st(ST_LOAD);
    chk("load outputs", {load, rst_n, pwr}, 17'h1ffff);
    endt("power on");
    req <= 8'h03;
    apb(1'b1, CLKEN_OFS, 32'h0f);
    apb(1'b0, CLKEN_OFS, 32'h0);
    chk("clken read", rd, 32'h0f);
    chk("gated clocks", {24'h0, clk_en}, 32'h0c);
    apb(1'b1, 12'h010, 32'hffffffff);
    chk("unmapped write err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", {rd[30:0], err}, 32'h1);
    chk("crystal speed", {31'h0, full}, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h8);
    apb(1'b1, CTRL_OFS, 32'ha);
    wait_st(ST_ACT);
    chk("full speed", {31'h0, full}, 32'h1);
    chk("active clocks", {radio, loop_en, xtal, clk_en}, 11'h70c);
    endt("active");
    apb(1'b1, CTRL_OFS, 32'hc);
    wait_st(ST_SLEEP);
    chk("sleep off", {radio, loop_en, xtal}, 3'h0);
    chk("sleep kept", {rst_n, pwr}, 16'hfffc);
    apb(1'b0, CLKEN_OFS, 32'h0);
    chk("sleep reg kept", rd, 32'h0f);
    wake_req <= 1'b1;
    for (n = 0; n < 20 && xtal !== 1'b1; n++) @(posedge pclk);
    wake_req <= 1'b0;
    chk("warm crystal first", {xtal, loop_en, radio}, 3'h4);
    for (n = 0; n < 20 && loop_en !== 1'b1; n++) @(posedge pclk);
    chk("warm loop", {xtal, loop_en, radio}, 3'h6);
    wait_st(ST_ACT);
    endt("wake line");
    apb(1'b1, SLPTM_OFS, 32'd60);
    apb(1'b1, CTRL_OFS, 32'hc);
    repeat (20) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("timer not early", {24'h0, rd[7:0]}, 32'h40);
    wait_st(ST_ACT);
    endt("sleep timer");
    @(posedge pclk);
    power_req <= 1'b0;
    @(posedge pclk);
    #3;
    chk("async off", {core_pwr, load, radio, rst_n}, 11'h0);
    power_cycle(3'h5);
    wait_st(ST_WAIT);
    chk("reserved strap", rd, 32'h004);
    chk("reserved usb", {31'h0, usb}, 32'h0);
    chk("fresh clken", {24'h0, clk_en}, 32'h0);
    apb(1'b0, CLKEN_OFS, 32'h0);
    chk("fresh clken reg", rd, {24'h0, CLKEN_RST[7:0]});
    endt("enable pulse");
    supply_ok <= 1'b0;
    wait_st(ST_OFF);
    chk("lockout", {23'h0, rd[9], rd[7:0]}, 32'h101);
    supply_ok <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("lockout sticky", {23'h0, rd[9], rd[7:0], core_pwr}, 32'h202);
    supply_ok <= 1'b0;
    power_cycle(3'h0);
    repeat (40) @(posedge pclk);
    chk("low supply start", {31'h0, core_pwr}, 32'h0);
    supply_ok <= 1'b1;
    power_cycle(3'h0);
    wait_st(ST_WAIT);
    chk("flash strap", rd, 32'h004);
    endt("lockout");
    give_verdict;
  end
endmodule
